// ===== dv/tof_echo_model.sv
// Far-side model: times the START pulse and returns echo stop pulses.
`timescale 1ns/10ps
module tof_echo_model (
  input  wire logic       clk_in,
  input  wire logic       clear_in,
  input  wire logic       start_in,
  input  wire logic       listen_in,
  input  wire logic [2:0] echo_count_in,
  output logic            stop_out,
  output logic [7:0]      start_width_out
);
  logic [2:0] sent_reg;   // Echoes already returned in this window.
  logic [3:0] phase_reg;  // Spacing counter between echoes.

  // The converter counts the clock cycles for which START stays high.
  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      start_width_out <= 8'h00;
    end else if (start_in) begin
      start_width_out <= start_width_out + 8'h01;
    end
  end

  // Echoes come only while the sequencer listens, one every 16 cycles, two cycles wide.
  // Outside the window the line rests low, so no stale edge can be counted.
  always_ff @(posedge clk_in) begin
    if (!listen_in) begin
      sent_reg  <= 3'h0;
      phase_reg <= 4'h0;
      stop_out  <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
      stop_out  <= (phase_reg[3:1] == 3'h7) && (sent_reg < echo_count_in);
      if (phase_reg == 4'hF && sent_reg < echo_count_in) begin
        sent_reg <= sent_reg + 3'h1;
      end
    end
  end
endmodule

// ===== dv/tof_measurement_sequencer_tb_top.sv
// Self-checking bench for the time-of-flight sequencer.
`timescale 1ns/10ps
module tof_measurement_sequencer_tb_top
  import tof_seq_pkg::*;
;
  // One ordinary measurement: its settings and what decides its outcome.
  typedef struct packed {
    logic [9:0] delay;
    logic       force_s;
    logic       blank;
    logic [4:0] pulses;
    logic [1:0] az;
    logic [1:0] blen;
    logic [1:0] tsel;
    logic [2:0] stops;
    logic [2:0] echoes;
    logic [1:0] mode;
    logic       refd;
    logic [2:0] txd;
  } row_t;

  // Rows 0 to 5 are plain runs; row 6 is the averaging run used later.
  row_t rows [7] = '{
    '{10'h01D, 1'h0, 1'h0, 5'h01, 2'h0, 2'h0, 2'h0, 3'h2, 3'h2, 2'h0, 1'h0, 3'h0},
    '{10'h01E, 1'h0, 1'h0, 5'h02, 2'h1, 2'h0, 2'h1, 3'h3, 3'h1, 2'h1, 1'h0, 3'h0},
    '{10'h01E, 1'h1, 1'h0, 5'h05, 2'h2, 2'h2, 2'h0, 3'h1, 3'h0, 2'h0, 1'h0, 3'h0},
    '{10'h100, 1'h0, 1'h1, 5'h03, 2'h0, 2'h0, 2'h0, 3'h1, 3'h1, 2'h2, 1'h0, 3'h0},
    '{10'h040, 1'h0, 1'h0, 5'h00, 2'h3, 2'h1, 2'h2, 3'h7, 3'h7, 2'h1, 1'h1, 3'h1},
    '{10'h3FF, 1'h0, 1'h1, 5'h1F, 2'h0, 2'h3, 2'h3, 3'h2, 3'h0, 2'h0, 1'h0, 3'h2},
    '{10'h000, 1'h0, 1'h0, 5'h01, 2'h0, 2'h0, 2'h0, 3'h1, 3'h1, 2'h2, 1'h0, 3'h0}};

  logic       clk_in         = 1'b0;
  logic       nrst_in        = 1'b0;
  logic       enable_in      = 1'b0;
  logic       trigger_in     = 1'b0;
  logic       err_wr_in      = 1'b0;
  logic [1:0] err_wr_data_in = 2'h0;
  logic       echo_on        = 1'b0;  // Keeps the stop line quiet until reset is done.
  logic       width_clear    = 1'b0;
  logic [2:0] echo_count     = 3'h0;
  seq_cfg_t   cfg            = '0;
  logic       echo_stop;
  logic [7:0] start_width;
  logic       start_out, tx_burst_out, rx_enable_out, rx_power_out, mux_alt_out;
  logic       autozero_out, cm_settle_out, listen_out, error_out_n, active_channel_out;
  logic [1:0] err_flags_out;
  logic [2:0] stop_count_out;
  seq_state_t state_out;
  seq_state_t end_state;
  int         num_errors = 0;
  int         comparisons = 0;
  int         cnt [16];
  int         starts, mux_n, rx_n, pw_off, outs;

  always #10 clk_in = ~clk_in;

  tof_measurement_sequencer u_tof_measurement_sequencer (
    .clk_in(clk_in), .nrst_in(nrst_in), .enable_in(enable_in), .trigger_in(trigger_in),
    .stop_in(echo_stop & echo_on), .cfg_in(cfg), .err_wr_in(err_wr_in),
    .err_wr_data_in(err_wr_data_in), .start_out(start_out), .tx_burst_out(tx_burst_out),
    .rx_enable_out(rx_enable_out), .rx_power_out(rx_power_out), .mux_alt_out(mux_alt_out),
    .autozero_out(autozero_out), .cm_settle_out(cm_settle_out), .listen_out(listen_out),
    .error_out_n(error_out_n), .err_flags_out(err_flags_out),
    .stop_count_out(stop_count_out), .active_channel_out(active_channel_out),
    .state_out(state_out));

  tof_echo_model u_tof_echo_model (
    .clk_in(clk_in), .clear_in(width_clear), .start_in(start_out), .listen_in(listen_out),
    .echo_count_in(echo_count), .stop_out(echo_stop), .start_width_out(start_width));

  // Inputs move on the falling edge, so every sample here is settled.
  task automatic tick();
    @(negedge clk_in);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A wait that runs out is a hang; it is counted and ends the run.
  task automatic wait_state(input seq_state_t s, input int bound);
    for (int i = 0; i < bound && state_out !== s; i++) tick();
    if (state_out !== s) begin
      num_errors++;
      $display("mismatch at %0t: wait for state %0d ran out", $time, s);
      end_of_test();
    end
  endtask

  task automatic err_write(input logic [1:0] d);
    err_wr_in      = 1'b1;
    err_wr_data_in = d;
    tick();
    err_wr_in = 1'b0;
    tick();
  endtask

  // Triggers one measurement and counts cycles per state until listening ends.
  task automatic measure();
    seq_state_t prev;
    logic       done;
    cnt    = '{default: 0};
    starts = 0;
    mux_n  = 0;
    rx_n   = 0;
    pw_off = 0;
    outs   = 0;
    prev   = READY;
    done   = 1'b0;
    for (int i = 0; i < 20000 && !done; i++) begin
      tick();
      trigger_in  = (i < 3);
      width_clear = (i == 0);
      cnt[state_out]++;
      starts += (start_out === 1'b1);
      if (state_out inside {ALIGN_SLOW, ALIGN_FAST, TX_BURST, MASK}) begin
        mux_n += (mux_alt_out === 1'b1);
        rx_n  += (rx_enable_out === 1'b1);
      end
      pw_off += (state_out == POWER_WAIT && rx_power_out === 1'b0);
      // The burst, auto-zero and settle outputs must be high exactly while their phase runs.
      outs += (tx_burst_out !== (state_out == TX_BURST));
      outs += (autozero_out !== (state_out == AUTOZERO));
      outs += (cm_settle_out !== (state_out == CM_SETTLE));
      if (prev == LISTEN && state_out != LISTEN) begin
        done      = 1'b1;
        end_state = state_out;
      end
      prev = state_out;
    end
    // A measurement that never ends is a hang, even if stuck in listening.
    if (!done) begin
      num_errors++;
      $display("mismatch at %0t: measurement never finished", $time);
      end_of_test();
    end
  endtask

  task automatic run_row(input row_t r);
    int   t0, t1, ext, span;
    logic s, late;
    t0   = r.refd ? 2 : 1;
    t1   = 2 << r.txd;
    s    = (r.delay < SHORT_THRESHOLD) || r.force_s;
    late = r.echoes < r.stops;
    ext  = (!s && !r.blank) ? r.delay * 8 : 0;
    cfg.result_high_register = r.delay[9:8];
    cfg.result_low_register  = r.delay[7:0];
    cfg.force_short_sequence = r.force_s;
    cfg.rx_power_gate_enable = r.blank;
    cfg.pulse_count          = r.pulses;
    cfg.autozero_length      = r.az;
    cfg.short_blank_interval = r.blen;
    cfg.listen_timeout_select = r.tsel;
    cfg.expected_stop_count  = r.stops;
    cfg.measure_mode         = r.mode;
    cfg.ref_clock_divide     = r.refd;
    cfg.tx_clock_divide      = r.txd;
    echo_count = r.echoes;
    wait_state(READY, 50);
    measure();
    span = cnt[ALIGN_SLOW] + cnt[ALIGN_FAST] + cnt[TX_BURST] + cnt[MASK];
    check(starts, ((r.pulses < 3) ? r.pulses : 3) * t1);
    check(start_width, ((r.pulses < 3) ? r.pulses : 3) * t1);
    check(cnt[TX_BURST], ((r.pulses > 0) ? r.pulses : 1) * t1);
    check(cnt[ALIGN_SLOW], 3 * t0);
    check(cnt[CM_SETTLE], 128 * t0);
    check(cnt[AUTOZERO], (64 << r.az) * t0);
    check(cnt[MASK], s ? (8 << r.blen) * t0 : 0);
    check(rx_n, s ? span : 0);
    if (s) check(mux_n, span);
    check(pw_off, (r.blank && !s) ? r.delay * 8 * t0 : 0);
    check(cnt[POWER_WAIT], (r.blank && !s) ? r.delay * 8 * t0 : 0);
    if (late) check(cnt[LISTEN], ((128 << r.tsel) + ext) * t0);
    check(end_state, (late || r.mode == MODE_AVG) ? READY : SLEEP);
    check(outs, 0);
    check(stop_count_out, late ? r.echoes : r.stops);
    tick();
    tick();
    check(err_flags_out, late ? ((r.echoes == 0) ? 2'h2 : 2'h1) : 2'h0);
    check(error_out_n, !late);
    err_write(2'h1);
    check({error_out_n, err_flags_out}, 3'h4);
  endtask

  initial begin
    repeat (20) tick();
    check({start_out, listen_out, error_out_n, err_flags_out}, 5'h04);
    check(state_out, SLEEP);
    nrst_in   = 1'b1;
    echo_on   = 1'b1;
    enable_in = 1'b1;
    for (int k = 0; k < 6; k++) run_row(rows[k]);
    // Averaging: the channel holds for two runs, then swaps; a state clear undoes it.
    cfg.average_exponent  = 3'h1;
    cfg.auto_channel_swap = 1'b1;
    err_write(2'h2);
    run_row(rows[6]);
    check(active_channel_out, 1'b0);
    run_row(rows[6]);
    check(active_channel_out, 1'b1);
    err_write(2'h2);
    check(active_channel_out, 1'b0);
    // Wait limit off: listening outlasts the window until forced out.
    cfg.echo_wait_limit_disable = 1'b1;
    echo_count = 3'h0;
    for (int k = 0; k < 2; k++) begin
      wait_state(READY, 50);
      trigger_in = 1'b1;
      wait_state(LISTEN, 2000);
      trigger_in = 1'b0;
      repeat (600) tick();  // Abort long before the receive path has been active for long.
      check(state_out, LISTEN);
      if (k == 0) begin
        err_write(2'h3);
        check(state_out, READY);
      end else begin
        enable_in = 1'b0;
        wait_state(SLEEP, 8);
        check(state_out, SLEEP);
        enable_in = 1'b1;
      end
    end
    end_of_test();
  end
endmodule

// ===== rtl/tof_measurement_sequencer.sv
// Transmit and receive phase sequencer for one time-of-flight measurement.
`timescale 1ns/10ps
// Behaviour
// (R01) START lasts min(pulse count, 3) T1
// (R02) Short: receive on early, mux alternate
// (R03) Short: mask on alternate after burst
// (R04) Short when delay below 30 or forced
// (R05) Delay count is high 2, low 8
// (R06) Standard: receive on after burst only
// (R07) Auto-zero length from autozero_length
// (R08) Window from timeout select, plus delay
// (R09) Too few stops: flag, pin low, READY
// (R10) Blanking: receive chain off during delay
// (R11) Common-mode window is 128 T0
// (R12) Delay extends window only unblanked standard
// (R13) Wait limit disabled: no timeout exit
// (R14) Clear write, enable low leave receive
// (R15) Bit1 clears sequencer, bit0 clears flags
// (R16) Host keeps receive under 100 ms
// (R17) Mode 2 stays 2^exponent triggers per channel
// (R18) Auto swap channel after each run (code swaps only in mode 2, after each group of 2^exponent runs)
// (R19) Done: SLEEP modes 0/1, READY mode 2
// (R20) T0 and T1 divided from clock
// (R21) START 3 T0 plus 2-3 T1 after trigger
// (R22) Selection latched at trigger, unsigned compare
module tof_measurement_sequencer
  import tof_seq_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       enable_in,
  input  wire logic       trigger_in,
  input  wire logic       stop_in,
  input  wire seq_cfg_t   cfg_in,
  input  wire logic       err_wr_in,
  input  wire logic [1:0] err_wr_data_in,
  output logic            start_out,
  output logic            tx_burst_out,
  output logic            rx_enable_out,
  output logic            rx_power_out,
  output logic            mux_alt_out,
  output logic            autozero_out,
  output logic            cm_settle_out,
  output logic            listen_out,
  output logic            error_out_n,
  output logic [1:0]      err_flags_out,
  output logic [2:0]      stop_count_out,
  output logic            active_channel_out,
  output seq_state_t      state_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  seq_state_t  state_reg,   state_next;   // Sequencer state.
  logic [15:0] cnt_reg,     cnt_next;     // Phase length in T0 periods.
  logic [4:0]  t1_idx_reg,  t1_idx_next;  // T1 periods done in the phase.
  logic [2:0]  stops_reg,   stops_next;   // Stop events seen while listening.
  logic [1:0]  flags_reg,   flags_next;   // Weak and no-signal flags.
  logic [7:0]  avg_reg,     avg_next;     // Triggers done on this channel.
  logic        swap_reg,    swap_next;    // Channel flipped from channel_pick.
  logic        short_reg,   short_next;   // Latched sequence choice.
  logic        blank_reg,   blank_next;   // Latched power blanking choice.
  logic [9:0]  delay_reg,   delay_next;   // Latched listen delay count.
  logic        t0_pre_reg;                // T0 prescaler.
  logic [7:0]  t1_pre_reg;                // T1 prescaler.
  logic        en_s1_reg, en_s2_reg;      // Enable synchroniser.
  logic        tr_s1_reg, tr_s2_reg, tr_s3_reg;  // Trigger synchroniser.
  logic        st_s1_reg, st_s2_reg, st_s3_reg;  // Stop synchroniser.
  logic        timeout, meas_done;        // One-cycle end events.

  // Pins are asynchronous; the first flop never feeds logic (enable uses the second, trigger and stop the second and third).
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      {en_s1_reg, en_s2_reg} <= 2'h0;
      {tr_s1_reg, tr_s2_reg, tr_s3_reg} <= 3'h0;
      {st_s1_reg, st_s2_reg, st_s3_reg} <= 3'h0;
    end else begin
      {en_s1_reg, en_s2_reg} <= {enable_in, en_s1_reg};
      {tr_s1_reg, tr_s2_reg, tr_s3_reg} <= {trigger_in, tr_s1_reg, tr_s2_reg};
      {st_s1_reg, st_s2_reg, st_s3_reg} <= {stop_in, st_s1_reg, st_s2_reg};
    end
  end

  wire trig_edge = tr_s2_reg & ~tr_s3_reg;  // Rising trigger edge.
  wire stop_edge = st_s2_reg & ~st_s3_reg;  // Rising stop edge.

  // T1 runs free so alignment follows the trigger phase; T0 restarts per phase.
  wire [7:0] t1_mask = 8'((9'h002 << cfg_in.tx_clock_divide) - 9'h001);
  wire       t0_tick = ~cfg_in.ref_clock_divide | t0_pre_reg;  // [R20]
  wire       t1_tick = &(t1_pre_reg | ~t1_mask);               // [R20]

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      t0_pre_reg <= 1'h0;
      t1_pre_reg <= 8'h00;
    end else begin
      t0_pre_reg <= cfg_in.ref_clock_divide & ~t0_pre_reg & (state_next == state_reg);
      t1_pre_reg <= t1_pre_reg + 8'h01;
    end
  end

  // Selection is decided fresh at every trigger.
  wire [9:0] listen_delay = {cfg_in.result_high_register,
                             cfg_in.result_low_register};          // [R05]
  wire pick_short = (listen_delay < SHORT_THRESHOLD)
                  | cfg_in.force_short_sequence;                   // [R04] [R22]

  // Phase lengths; the delay term only serves the standard sequence.
  wire [15:0] az_len    = AUTOZERO_BASE_T0 << cfg_in.autozero_length;     // [R07]
  wire [15:0] blank_len = BLANK_BASE_T0 << cfg_in.short_blank_interval;   // [R03]
  wire [15:0] delay_len = {6'h00, delay_reg} << DELAY_UNIT_SHIFT;
  wire [15:0] listen_len = (LISTEN_BASE_T0 << cfg_in.listen_timeout_select)
                         + ((!short_reg && !blank_reg) ? delay_len : 16'h0000);  // [R08] [R12]

  wire phase_end = t0_tick && (cnt_reg <= 16'h0001);
  wire [15:0] cnt_dec = (t0_tick && cnt_reg != 16'h0000) ? cnt_reg - 16'h0001 : cnt_reg;
  wire stops_hit = stops_reg >= cfg_in.expected_stop_count;
  wire clr_state = err_wr_in & err_wr_data_in[CLR_STATE_BIT];
  wire clr_flags = err_wr_in & err_wr_data_in[CLR_FLAGS_BIT];
  wire active    = (state_reg != SLEEP) && (state_reg != READY);
  wire abort     = !en_s2_reg || clr_state;
  wire mode_avg  = cfg_in.measure_mode == MODE_AVG;
  seq_state_t done_state;
  assign done_state = mode_avg ? READY : SLEEP;                    // [R19]
  wire [2:0] start_len = (cfg_in.pulse_count < 5'(START_MAX_T1)) ?
                         cfg_in.pulse_count[2:0] : START_MAX_T1;

  // Sequence order. Short: settle, auto-zero, align, burst, mask, listen.
  // Standard: align, burst, optional powered-down wait, settle, auto-zero,
  // listen. In the short case the START delay is counted from auto-zero end,
  // because the receive path must be settled before the burst.
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_dec;
    t1_idx_next = t1_idx_reg;
    short_next  = short_reg;
    blank_next  = blank_reg;
    delay_next  = delay_reg;
    timeout     = 1'b0;
    meas_done   = 1'b0;
    case (state_reg)
      SLEEP: begin
        if (en_s2_reg) begin
          state_next = READY;
        end
      end
      READY: begin
        if (trig_edge && en_s2_reg) begin
          short_next = pick_short;                                 // [R22]
          blank_next = cfg_in.rx_power_gate_enable & ~pick_short;  // [R10]
          delay_next = listen_delay;
          if (pick_short) begin
            state_next = CM_SETTLE;                                // [R02]
            cnt_next   = CM_SETTLE_T0;
          end else begin
            state_next = ALIGN_SLOW;                               // [R06]
            cnt_next   = ALIGN_T0;
          end
        end
      end
      CM_SETTLE: begin
        if (phase_end) begin
          state_next = AUTOZERO;
          cnt_next   = az_len;                                     // [R07]
        end
      end
      AUTOZERO: begin
        if (phase_end) begin
          state_next = short_reg ? ALIGN_SLOW : LISTEN;
          cnt_next   = short_reg ? ALIGN_T0 : listen_len;          // [R08]
        end
      end
      ALIGN_SLOW: begin
        if (phase_end) begin
          state_next  = ALIGN_FAST;
          t1_idx_next = 5'h00;
        end
      end
      ALIGN_FAST: begin
        // The first T1 boundary is partial, which gives 2 to 3 whole T1.
        if (t1_tick) begin
          t1_idx_next = t1_idx_reg + 5'h01;
          if (t1_idx_reg == ALIGN_T1 - 5'h01) begin
            state_next  = TX_BURST;                                // [R21]
            t1_idx_next = 5'h00;
          end
        end
      end
      TX_BURST: begin
        if (t1_tick) begin
          t1_idx_next = t1_idx_reg + 5'h01;
          if (t1_idx_reg + 5'h01 >= cfg_in.pulse_count) begin
            if (short_reg) begin
              state_next = MASK;                                   // [R03]
              cnt_next   = blank_len;
            end else if (blank_reg) begin
              state_next = POWER_WAIT;                             // [R10]
              cnt_next   = delay_len;
            end else begin
              state_next = CM_SETTLE;                              // [R11]
              cnt_next   = CM_SETTLE_T0;
            end
          end
        end
      end
      MASK: begin
        if (phase_end) begin
          state_next = LISTEN;
          cnt_next   = listen_len;                                 // [R08]
        end
      end
      POWER_WAIT: begin
        if (phase_end) begin
          state_next = CM_SETTLE;                                  // [R11]
          cnt_next   = CM_SETTLE_T0;
        end
      end
      LISTEN: begin
        if (stops_hit) begin
          state_next = done_state;                                 // [R19]
          meas_done  = 1'b1;
        end else if (phase_end && !cfg_in.echo_wait_limit_disable) begin
          state_next = READY;                                      // [R09] [R13]
          timeout    = 1'b1;
        end
      end
      default: begin
        state_next = SLEEP;
      end
    endcase
    // Forced exit wins over every phase, including an endless listen.
    if (active && abort) begin
      state_next = en_s2_reg ? READY : SLEEP;                      // [R14] [R15]
      timeout    = 1'b0;
      meas_done  = 1'b0;
    end else if (state_reg == READY && !en_s2_reg) begin
      state_next = SLEEP;
    end
  end

  // Stop counting saturates; it restarts with every trigger edge seen in READY.
  assign stops_next = (state_reg == READY && trig_edge) ? 3'h0 :
                      (state_reg == LISTEN && stop_edge && stops_reg != 3'h7) ?
                      stops_reg + 3'h1 : stops_reg;

  // A flag raised in the cycle of a clear survives the clear.
  wire [1:0] flag_set = {timeout && stops_reg == 3'h0, timeout && stops_reg != 3'h0};
  assign flags_next = (flags_reg & ~{2{clr_flags}}) | flag_set;   // [R09] [R15]

  // Averaging: each finished trigger cycle counts in mode 2.
  wire [7:0] avg_top = 8'((9'h001 << cfg_in.average_exponent) - 9'h001);
  wire       meas_end = (meas_done || timeout) && mode_avg;
  always_comb begin
    avg_next  = avg_reg;
    swap_next = swap_reg;
    if (clr_state) begin
      avg_next  = 8'h00;
      swap_next = 1'b0;
    end else if (meas_end) begin
      if (avg_reg >= avg_top) begin
        avg_next  = 8'h00;                                         // [R17]
        swap_next = swap_reg ^ cfg_in.auto_channel_swap;           // [R18]
      end else begin
        avg_next = avg_reg + 8'h01;                                // [R17]
      end
    end
  end

  // State and bookkeeping registers.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg  <= SLEEP;
      cnt_reg    <= 16'h0000;
      t1_idx_reg <= 5'h00;
      stops_reg  <= 3'h0;
      flags_reg  <= FLAGS_RESET;
      avg_reg    <= 8'h00;
      swap_reg   <= 1'b0;
      short_reg  <= 1'b1;  // Short sequence is the power-on choice.
      blank_reg  <= 1'b0;
      delay_reg  <= 10'h000;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      t1_idx_reg <= t1_idx_next;
      stops_reg  <= stops_next;
      flags_reg  <= flags_next;
      avg_reg    <= avg_next;
      swap_reg   <= swap_next;
      short_reg  <= short_next;
      blank_reg  <= blank_next;
      delay_reg  <= delay_next;
    end
  end

  // Output decode from registers; start_out and active_channel_out also use cfg_in.
  wire early_rx = (state_reg == ALIGN_SLOW) || (state_reg == ALIGN_FAST) ||
                  (state_reg == TX_BURST) || (state_reg == MASK);
  wire late_rx  = (state_reg == CM_SETTLE) || (state_reg == AUTOZERO) ||
                  (state_reg == LISTEN);
  assign rx_enable_out = late_rx || (short_reg && early_rx);       // [R02] [R06]
  assign rx_power_out  = active && (state_reg != POWER_WAIT);      // [R10]
  assign mux_alt_out   = short_reg ? (active && state_reg != LISTEN)
                                   : (state_reg == TX_BURST);      // [R02] [R03]
  assign start_out     = (state_reg == TX_BURST) &&
                         (t1_idx_reg < {2'h0, start_len});         // [R01]
  assign tx_burst_out  = state_reg == TX_BURST;
  assign autozero_out  = state_reg == AUTOZERO;
  assign cm_settle_out = state_reg == CM_SETTLE;
  assign listen_out    = state_reg == LISTEN;
  assign error_out_n   = ~|flags_reg;                              // [R09]
  assign err_flags_out = flags_reg;
  assign stop_count_out = stops_reg;
  assign active_channel_out = cfg_in.channel_pick ^ swap_reg;      // [R17] [R18]
  assign state_out     = state_reg;

  // Checks next to the sequencer.
  sequence s_expire;
    state_reg == LISTEN && phase_end && !stops_hit &&
    !cfg_in.echo_wait_limit_disable && !abort;
  endsequence
  sequence s_reported;
    state_reg == READY && !error_out_n;
  endsequence
  property p_start_len;
    start_out |-> t1_idx_reg < 5'(START_MAX_T1) && t1_idx_reg < cfg_in.pulse_count;
  endproperty
  a_start_len: assert property (p_start_len) else $error("START too long"); // [R01]
  property p_short_burst;
    (state_reg == TX_BURST && short_reg) |-> rx_enable_out && mux_alt_out;
  endproperty
  a_short_burst: assert property (p_short_burst) else $error("short burst routing"); // [R02]
  property p_mask;
    (state_reg == TX_BURST && short_reg && t1_tick && state_next == MASK)
      |=> mux_alt_out && cnt_reg == $past(blank_len);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not entered"); // [R03]
  property p_select;
    (state_reg == READY && trig_edge && en_s2_reg)
      |=> short_reg == ($past(listen_delay) < 10'h01E || $past(cfg_in.force_short_sequence));
  endproperty
  a_select: assert property (p_select) else $error("wrong sequence pick"); // [R04]
  property p_std_rx;
    (state_reg == TX_BURST && !short_reg) |-> !rx_enable_out;
  endproperty
  a_std_rx: assert property (p_std_rx) else $error("rx on in std burst"); // [R06]
  property p_timeout;
    s_expire |=> s_reported;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not reported"); // [R09]
  property p_no_limit;
    (state_reg == LISTEN && cfg_in.echo_wait_limit_disable && !stops_hit && !abort)
      |=> state_reg == LISTEN;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("left listen early"); // [R13]
  property p_cm_len;
    $rose(cm_settle_out) |-> cnt_reg == 16'h0080;
  endproperty
  a_cm_len: assert property (p_cm_len) else $error("settle window length"); // [R11]
  property p_clear;
    (active && clr_state) |=> (state_reg == READY || state_reg == SLEEP) && avg_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not stop"); // [R14]
  property p_done;
    (state_reg == LISTEN && stops_hit && !abort)
      |=> state_reg == ($past(mode_avg) ? READY : SLEEP);
  endproperty
  a_done: assert property (p_done) else $error("wrong end state"); // [R19]
endmodule

// ===== rtl/tof_seq_pkg.sv
// Constants, types and the configuration carrier for the time-of-flight sequencer.
package tof_seq_pkg;
  // Selection threshold for listen_delay_count; below it the short sequence runs.
  localparam logic [9:0]  SHORT_THRESHOLD  = 10'h01E;
  // START pulse never exceeds this many T1 periods.
  localparam logic [2:0]  START_MAX_T1     = 3'h3;
  // Common-mode settling window in T0 periods.
  localparam logic [15:0] CM_SETTLE_T0     = 16'h0080;
  // Trigger alignment: T0 periods, then T1 boundaries (gives 2 to 3 whole T1).
  localparam logic [15:0] ALIGN_T0         = 16'h0003;
  localparam logic [4:0]  ALIGN_T1         = 5'h03;
  // Base lengths in T0 periods, each doubled per step of its select field.
  localparam logic [15:0] AUTOZERO_BASE_T0 = 16'h0040;
  localparam logic [15:0] BLANK_BASE_T0    = 16'h0008;
  localparam logic [15:0] LISTEN_BASE_T0   = 16'h0080;
  // One step of listen_delay_count is this many T0 periods (as a shift).
  localparam int          DELAY_UNIT_SHIFT = 3;
  // Measurement mode that averages and returns to READY.
  localparam logic [1:0]  MODE_AVG         = 2'h2;
  // Error register bits: write side and flag side.
  localparam int          CLR_FLAGS_BIT    = 0;
  localparam int          CLR_STATE_BIT    = 1;
  localparam int          FLAG_WEAK_BIT    = 0;
  localparam int          FLAG_NOSIG_BIT   = 1;
  localparam logic [1:0]  FLAGS_RESET      = 2'h0;

  // Sequencer states.
  typedef enum logic [3:0] {
    SLEEP, READY, CM_SETTLE, AUTOZERO, ALIGN_SLOW, ALIGN_FAST,
    TX_BURST, MASK, POWER_WAIT, LISTEN
  } seq_state_t;

  // Configuration fields as software leaves them between measurements.
  typedef struct packed {
    logic [1:0] measure_mode;
    logic [4:0] pulse_count;
    logic [2:0] expected_stop_count;
    logic       force_short_sequence;
    logic       rx_power_gate_enable;
    logic       echo_wait_limit_disable;
    logic [1:0] listen_timeout_select;
    logic [1:0] short_blank_interval;
    logic [1:0] autozero_length;
    logic       ref_clock_divide;
    logic [2:0] tx_clock_divide;
    logic [2:0] average_exponent;
    logic       channel_pick;
    logic       auto_channel_swap;
    logic [1:0] result_high_register;
    logic [7:0] result_low_register;
  } seq_cfg_t;
endpackage
